// ### include/wsd_defines.svh
`ifndef WSD_DEFINES_SVH
`define WSD_DEFINES_SVH

`define WSD_LANES    8
`define WSD_FRF_STD  2'h0
`define WSD_PFS_STD  2'h0
`define WSD_PFS_ADDR 2'h1
`define WSD_PFS_WIDE 2'h2
`define WSD_ILEN_4   2'h1
`define WSD_ILEN_8   2'h2
`define WSD_ILEN_16  2'h3
`define WSD_DIV_MIN  8'h03
`define WSD_CFG_RST  '0

`endif

// ### include/wsd_pkg.sv
package wsd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INSTR,
      ST_ADDR,
      ST_WAIT,
      ST_DATA,
      ST_END
   } wsd_state_t;

   typedef struct packed {
      logic        rd;
      logic [1:0]  frf;
      logic [1:0]  pfs;
      logic [1:0]  ilen;
      logic [3:0]  alen;
      logic [4:0]  wait_n;
      logic [15:0] frames;
      logic [5:0]  fbits;
      logic        cpha;
      logic        cpol;
      logic        ad_ddr;
      logic        in_ddr;
      logic [7:0]  half;
      logic [15:0] instr;
      logic [59:0] addr;
   } wsd_cfg_t;

endpackage

// ### include/wsd_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface wsd_link_if;
   wsd_pkg::wsd_cfg_t cfg;
   logic              req_tog;
   logic              done_tog;
   logic              rx_tog;
   logic [31:0]       rx_hold;
   modport fe  (output cfg, output req_tog, input done_tog, input rx_tog, input rx_hold);
   modport eng (input cfg, input req_tog, output done_tog, output rx_tog, output rx_hold);
endinterface
`default_nettype wire

// ### verilog/wsd_front.sv
`timescale 1ns/1ns
`default_nettype none
`include "wsd_defines.svh"
module wsd_front (
   input  wire logic               mclk_in,
   input  wire logic               sys_rst_in,
   input  wire logic               start_in,
   input  wire wsd_pkg::wsd_cfg_t  cfg_in,
   wsd_link_if.fe                  lnk,
   output logic                    busy_out,
   output logic                    done_out,
   output logic                    rx_valid_out,
   output logic [31:0]             rx_data_out
);
   logic [2:0] done_sync_q;
   logic [2:0] rx_sync_q;
   logic       done_evt;
   logic       rx_evt;

   assign done_evt = done_sync_q[2] ^ done_sync_q[1];
   assign rx_evt   = rx_sync_q[2] ^ rx_sync_q[1];

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_sync_q <= 3'h0;
         rx_sync_q   <= 3'h0;
      end else begin
         done_sync_q <= {done_sync_q[1:0], lnk.done_tog};
         rx_sync_q   <= {rx_sync_q[1:0], lnk.rx_tog};
      end
   end

   // config is frozen while busy, so the link side may read it as static words
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lnk.cfg     <= `WSD_CFG_RST;
         lnk.req_tog <= 1'b0;
         busy_out    <= 1'b0;
      end else if (start_in && !busy_out) begin
         lnk.cfg     <= cfg_in;
         lnk.req_tog <= ~lnk.req_tog;
         busy_out    <= 1'b1;
      end else if (done_evt) begin
         busy_out <= 1'b0;
      end
   end

   // the hold word is stable for a whole frame time, far longer than the sync delay
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_out     <= 1'b0;
         rx_valid_out <= 1'b0;
         rx_data_out  <= 32'h0;
      end else begin
         done_out     <= done_evt;
         rx_valid_out <= rx_evt;
         if (rx_evt) begin
            rx_data_out <= lnk.rx_hold;
         end
      end
   end
endmodule
`default_nettype wire

// ### verilog/wsd_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "wsd_defines.svh"
// Behaviour
// - active lanes follow wide frame format: top lane 7, 3 or 1
// - a wide read runs instruction, address, turnaround wait, then data
// - turnaround count gives the wait directly in serial clock periods, zero means none
// - instruction and address go once, frames are collected, then target select releases
// - phase format 00 sends instruction and address on one lane, then the wait
// - phase format 01 sends instruction on one lane, address on wide lanes
// - phase format 10 sends instruction and address on the wide lanes
// - a bare read waits the turnaround periods then collects one frame more than the frame count
// - address width is four times the address length code
// - single-lane data is sampled on receive lane 1
// - every frame protocol shares this fixed lane mapping
// - double rate is allowed only in clock modes 0 and 3
// - address/data double rate moves address and data on both edges
// - instruction double rate puts the whole command on both edges
// - double rate enables count only in dual, quad or octal operation
// - standard frame format sends everything on one lane, ignoring phase format
module wsd_ctrl (
   input  wire logic                  mclk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  ser_clk_in,
   input  wire logic                  data_port_wr_in,
   input  wire logic                  xfer_read_in,
   input  wire logic [15:0]           instr_in,
   input  wire logic [59:0]           addr_in,
   input  wire logic [1:0]            wide_frame_format_in,
   input  wire logic [1:0]            phase_format_select_in,
   input  wire logic [1:0]            instr_length_code_in,
   input  wire logic [3:0]            addr_length_code_in,
   input  wire logic [4:0]            wait_count_in,
   input  wire logic [15:0]           frame_count_in,
   input  wire logic [5:0]            frame_bits_in,
   input  wire logic                  clock_phase_in,
   input  wire logic                  clock_polarity_in,
   input  wire logic                  addr_data_ddr_en_in,
   input  wire logic                  double_rate_instr_en_in,
   input  wire logic [7:0]            baud_half_in,
   input  wire logic [`WSD_LANES-1:0] rxd_in,
   output logic                       busy_out,
   output logic                       done_out,
   output logic                       rx_valid_out,
   output logic [31:0]                rx_data_out,
   output logic                       sclk_out,
   output logic                       ss_n_out,
   output logic [`WSD_LANES-1:0]      txd_out,
   output logic [`WSD_LANES-1:0]      lane_oe_n_out
);
   localparam int LANES = `WSD_LANES;

   wsd_link_if lnk ();

   wsd_pkg::wsd_cfg_t   cmd_cfg;
   wsd_pkg::wsd_cfg_t   cfg;
   wsd_pkg::wsd_state_t st_q;
   wsd_pkg::wsd_state_t first_st;
   wsd_pkg::wsd_state_t nxt_st;
   logic [2:0]          req_sync_q;
   logic [LANES-1:0]    rxd_s1_q;
   logic [LANES-1:0]    rxd_s2_q;
   logic [7:0]          hcnt_q;
   logic [7:0]          half_m1;
   logic                sclk_q;
   logic                ss_n_q;
   logic [LANES-1:0]    txd_q;
   logic [LANES-1:0]    oe_n_q;
   logic [63:0]         tx_sr_q;
   logic [31:0]         rx_sr_q;
   logic [31:0]         rx_next;
   logic [31:0]         rx_hold_q;
   logic                rx_tog_q;
   logic                done_tog_q;
   logic [6:0]          ucnt_q;
   logic [16:0]         fcnt_q;
   logic                pend_q;
   logic                start_evt;
   logic                tick;
   logic                lead;
   logic                ddr_ok;
   logic                ddr_now;
   logic                samp;
   logic                drv;
   logic                unit_last;
   logic                frame_last;
   logic [1:0]          cur_lg;

   assign cmd_cfg = '{rd:     xfer_read_in,
                      frf:    wide_frame_format_in,
                      pfs:    phase_format_select_in,
                      ilen:   instr_length_code_in,
                      alen:   addr_length_code_in,
                      wait_n: wait_count_in,
                      frames: frame_count_in,
                      fbits:  frame_bits_in,
                      cpha:   clock_phase_in,
                      cpol:   clock_polarity_in,
                      ad_ddr: addr_data_ddr_en_in,
                      in_ddr: double_rate_instr_en_in,
                      half:   baud_half_in,
                      instr:  instr_in,
                      addr:   addr_in};

   wsd_front u_front (
      .mclk_in      (mclk_in),
      .sys_rst_in   (sys_rst_in),
      .start_in     (data_port_wr_in),
      .cfg_in       (cmd_cfg),
      .lnk          (lnk),
      .busy_out     (busy_out),
      .done_out     (done_out),
      .rx_valid_out (rx_valid_out),
      .rx_data_out  (rx_data_out)
   );

   assign cfg          = lnk.cfg;
   assign lnk.done_tog = done_tog_q;
   assign lnk.rx_tog   = rx_tog_q;
   assign lnk.rx_hold  = rx_hold_q;

   assign sclk_out      = sclk_q;
   assign ss_n_out      = ss_n_q;
   assign txd_out       = txd_q;
   assign lane_oe_n_out = oe_n_q;

   function automatic logic [6:0] ilen_bits(input logic [1:0] code);
      logic [6:0] b;
      b = 7'h00;
      if (code == `WSD_ILEN_4) b = 7'h04;
      else if (code == `WSD_ILEN_8) b = 7'h08;
      else if (code == `WSD_ILEN_16) b = 7'h10;
      ilen_bits = b;
   endfunction

   // log2 of the lane count used by a phase
   function automatic logic [1:0] lane_lg(input wsd_pkg::wsd_state_t s, input wsd_pkg::wsd_cfg_t c);
      logic wide;
      wide = 1'b1;
      if (c.frf == `WSD_FRF_STD) wide = 1'b0;
      else if (s == wsd_pkg::ST_INSTR) wide = (c.pfs == `WSD_PFS_WIDE);
      else if (s == wsd_pkg::ST_ADDR) wide = (c.pfs == `WSD_PFS_ADDR) || (c.pfs == `WSD_PFS_WIDE);
      lane_lg = wide ? c.frf : 2'h0;
   endfunction

   function automatic logic is_tx(input wsd_pkg::wsd_state_t s);
      is_tx = (s == wsd_pkg::ST_INSTR) || (s == wsd_pkg::ST_ADDR);
   endfunction

   function automatic logic [6:0] phase_units(input wsd_pkg::wsd_state_t s, input wsd_pkg::wsd_cfg_t c);
      logic [6:0] b;
      logic [6:0] u;
      b = 7'h00;
      u = 7'h00;
      if (s == wsd_pkg::ST_INSTR) b = ilen_bits(c.ilen);
      else if (s == wsd_pkg::ST_ADDR) b = {1'b0, c.alen, 2'h0};
      else if (s == wsd_pkg::ST_DATA) b = {1'b0, c.fbits};
      u = b >> lane_lg(s, c);
      if (s == wsd_pkg::ST_WAIT) phase_units = {2'h0, c.wait_n};
      else if (u == 7'h00) phase_units = 7'h01;
      else phase_units = u;
   endfunction

   // msb of the phase sits at the top of the shifter
   function automatic logic [63:0] load_sr(input wsd_pkg::wsd_state_t s, input wsd_pkg::wsd_cfg_t c);
      logic [63:0] v;
      v = 64'h0;
      if (s == wsd_pkg::ST_INSTR) v = {c.instr, 48'h0} << (7'h10 - ilen_bits(c.ilen));
      else if (s == wsd_pkg::ST_ADDR) v = {c.addr, 4'h0} << (7'h3c - {1'b0, c.alen, 2'h0});
      load_sr = v;
   endfunction

   // instruction, address and wait phases with zero length are skipped
   function automatic wsd_pkg::wsd_state_t nxt(input wsd_pkg::wsd_state_t s, input wsd_pkg::wsd_cfg_t c);
      wsd_pkg::wsd_state_t n;
      logic                early;
      early = (s == wsd_pkg::ST_IDLE) || (s == wsd_pkg::ST_INSTR) || (s == wsd_pkg::ST_ADDR);
      n = wsd_pkg::ST_END;
      if (s == wsd_pkg::ST_IDLE && c.ilen != 2'h0) n = wsd_pkg::ST_INSTR;
      else if ((s == wsd_pkg::ST_IDLE || s == wsd_pkg::ST_INSTR) && c.alen != 4'h0) n = wsd_pkg::ST_ADDR;
      else if (early && c.rd && c.wait_n != 5'h00) n = wsd_pkg::ST_WAIT;
      else if (s != wsd_pkg::ST_DATA && c.rd) n = wsd_pkg::ST_DATA;
      nxt = n;
   endfunction

   function automatic logic [LANES-1:0] tx_lanes(input logic [63:0] sr, input logic [1:0] lg);
      logic [LANES-1:0] v;
      v = sr[63:56];
      if (lg == 2'h0) v = {7'h00, sr[63]};
      else if (lg == 2'h1) v = {6'h00, sr[63:62]};
      else if (lg == 2'h2) v = {4'h0, sr[63:60]};
      tx_lanes = v;
   endfunction

   // single lane drives lane 0 only, lane 1 stays an input
   function automatic logic [LANES-1:0] lane_oe_n(input logic [1:0] lg);
      logic [LANES-1:0] v;
      v = 8'h00;
      if (lg == 2'h0) v = 8'hfe;
      else if (lg == 2'h1) v = 8'hfc;
      else if (lg == 2'h2) v = 8'hf0;
      lane_oe_n = v;
   endfunction

   function automatic logic [63:0] sr_shift(input logic [63:0] sr, input logic [1:0] lg);
      logic [63:0] v;
      v = {sr[55:0], 8'h00};
      if (lg == 2'h0) v = {sr[62:0], 1'b0};
      else if (lg == 2'h1) v = {sr[61:0], 2'h0};
      else if (lg == 2'h2) v = {sr[59:0], 4'h0};
      sr_shift = v;
   endfunction

   function automatic logic [31:0] rx_shift(input logic [31:0] sr, input logic [LANES-1:0] d,
                                            input logic [1:0] lg);
      logic [31:0] v;
      v = {sr[23:0], d[7:0]};
      if (lg == 2'h0) v = {sr[30:0], d[1]};
      else if (lg == 2'h1) v = {sr[29:0], d[1:0]};
      else if (lg == 2'h2) v = {sr[27:0], d[3:0]};
      rx_shift = v;
   endfunction

   assign start_evt  = req_sync_q[2] ^ req_sync_q[1];
   assign first_st   = nxt(wsd_pkg::ST_IDLE, cfg);
   assign nxt_st     = nxt(st_q, cfg);
   assign half_m1    = (cfg.half < `WSD_DIV_MIN) ? (`WSD_DIV_MIN - 8'h01) : (cfg.half - 8'h01);
   assign tick       = (st_q != wsd_pkg::ST_IDLE) && (hcnt_q == half_m1);
   assign lead       = (sclk_q == cfg.cpol);
   assign ddr_ok     = (cfg.frf != `WSD_FRF_STD) && (cfg.cpha == cfg.cpol);
   assign cur_lg     = lane_lg(st_q, cfg);
   assign unit_last  = (ucnt_q == 7'h01);
   assign frame_last = (fcnt_q == 17'h00001);
   assign rx_next    = rx_shift(rx_sr_q, rxd_s2_q, cur_lg);

   // address/data rate also follows the instruction enable, so the whole command is double rate
   always_comb begin
      ddr_now = 1'b0;
      if (st_q == wsd_pkg::ST_INSTR) ddr_now = ddr_ok && cfg.in_ddr;
      else if (st_q == wsd_pkg::ST_ADDR || st_q == wsd_pkg::ST_DATA) ddr_now = ddr_ok && (cfg.ad_ddr || cfg.in_ddr);
   end

   // pend marks a fresh phase whose first unit must be driven before anything is sampled
   assign samp = tick && !pend_q && (ddr_now || (lead ^ cfg.cpha));
   assign drv  = tick && (pend_q || ddr_now || !(lead ^ cfg.cpha));

   always_ff @(posedge ser_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         req_sync_q <= 3'h0;
         rxd_s1_q   <= '0;
         rxd_s2_q   <= '0;
      end else begin
         req_sync_q <= {req_sync_q[1:0], lnk.req_tog};
         rxd_s1_q   <= rxd_in;
         rxd_s2_q   <= rxd_s1_q;
      end
   end

   always_ff @(posedge ser_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hcnt_q <= 8'h00;
         sclk_q <= 1'b0;
      end else if (st_q == wsd_pkg::ST_IDLE) begin
         hcnt_q <= 8'h00;
         sclk_q <= cfg.cpol;
      end else if (tick) begin
         hcnt_q <= 8'h00;
         if (!(st_q == wsd_pkg::ST_END && lead)) begin
            sclk_q <= ~sclk_q;
         end
      end else begin
         hcnt_q <= hcnt_q + 8'h01;
      end
   end

   always_ff @(posedge ser_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_q       <= wsd_pkg::ST_IDLE;
         ucnt_q     <= 7'h00;
         fcnt_q     <= 17'h00000;
         pend_q     <= 1'b0;
         tx_sr_q    <= 64'h0;
         txd_q      <= '0;
         oe_n_q     <= '1;
         ss_n_q     <= 1'b1;
         done_tog_q <= 1'b0;
      end else begin
         case (st_q)
            wsd_pkg::ST_IDLE: begin
               if (start_evt) begin
                  ss_n_q <= 1'b0;
                  st_q   <= first_st;
                  ucnt_q <= phase_units(first_st, cfg);
                  fcnt_q <= {1'b0, cfg.frames} + 17'h00001;
                  // mode 1 and 3 drive on the first edge, modes 0 and 2 before it
                  if (is_tx(first_st) && !cfg.cpha) begin
                     txd_q   <= tx_lanes(load_sr(first_st, cfg), lane_lg(first_st, cfg));
                     oe_n_q  <= lane_oe_n(lane_lg(first_st, cfg));
                     tx_sr_q <= sr_shift(load_sr(first_st, cfg), lane_lg(first_st, cfg));
                     pend_q  <= 1'b0;
                  end else begin
                     tx_sr_q <= load_sr(first_st, cfg);
                     pend_q  <= 1'b1;
                  end
               end
            end
            wsd_pkg::ST_END: begin
               if (lead) begin
                  ss_n_q     <= 1'b1;
                  oe_n_q     <= '1;
                  st_q       <= wsd_pkg::ST_IDLE;
                  done_tog_q <= ~done_tog_q;
               end
            end
            default: begin
               if (samp && unit_last && !(st_q == wsd_pkg::ST_DATA && !frame_last)) begin
                  st_q    <= nxt_st;
                  ucnt_q  <= phase_units(nxt_st, cfg);
                  tx_sr_q <= load_sr(nxt_st, cfg);
                  pend_q  <= 1'b1;
                  if (!is_tx(nxt_st)) begin
                     oe_n_q <= '1;
                  end
               end else begin
                  if (samp) begin
                     ucnt_q <= unit_last ? phase_units(st_q, cfg) : (ucnt_q - 7'h01);
                  end
                  if (samp && unit_last) begin
                     fcnt_q <= fcnt_q - 17'h00001;
                  end
                  if (drv) begin
                     pend_q <= 1'b0;
                     if (is_tx(st_q)) begin
                        txd_q   <= tx_lanes(tx_sr_q, cur_lg);
                        oe_n_q  <= lane_oe_n(cur_lg);
                        tx_sr_q <= sr_shift(tx_sr_q, cur_lg);
                     end
                  end
               end
            end
         endcase
      end
   end

   // frames land right-aligned, so short frames need no masking downstream
   always_ff @(posedge ser_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rx_sr_q   <= 32'h0;
         rx_hold_q <= 32'h0;
         rx_tog_q  <= 1'b0;
      end else if (st_q == wsd_pkg::ST_IDLE) begin
         rx_sr_q <= 32'h0;
      end else if (samp && st_q == wsd_pkg::ST_DATA) begin
         if (unit_last) begin
            rx_hold_q <= rx_next;
            rx_tog_q  <= ~rx_tog_q;
            rx_sr_q   <= 32'h0;
         end else begin
            rx_sr_q <= rx_next;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/wsd_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "wsd_defines.svh"
module wsd_chk (
   input wire logic                  mclk_in,
   input wire logic                  sys_rst_in,
   input wire logic                  ser_clk_in,
   input wire logic                  data_port_wr_in,
   input wire logic                  busy_out,
   input wire logic                  done_out,
   input wire logic                  rx_valid_out,
   input wire logic [31:0]           rx_data_out,
   input wire logic                  ss_n_out,
   input wire logic [`WSD_LANES-1:0] lane_oe_n_out
);
   sequence s_take;
      data_port_wr_in && !busy_out;
   endsequence
   sequence s_sel;
      ##[0:40] !ss_n_out;
   endsequence
   property p_launch;
      @(posedge mclk_in) disable iff (sys_rst_in) s_take |=> busy_out throughout s_sel;
   endproperty
   property p_done_pulse;
      @(posedge mclk_in) disable iff (sys_rst_in) done_out |=> !done_out;
   endproperty
   property p_done_clr;
      @(posedge mclk_in) disable iff (sys_rst_in) done_out |-> !busy_out;
   endproperty
   property p_busy_end;
      @(posedge mclk_in) disable iff (sys_rst_in) $fell(busy_out) |-> done_out;
   endproperty
   property p_ss_busy;
      @(posedge mclk_in) disable iff (sys_rst_in) !ss_n_out |-> busy_out;
   endproperty
   property p_rx_busy;
      @(posedge mclk_in) disable iff (sys_rst_in) rx_valid_out |-> busy_out;
   endproperty
   property p_rx_pulse;
      @(posedge mclk_in) disable iff (sys_rst_in) rx_valid_out |=> !rx_valid_out;
   endproperty
   property p_rx_hold;
      @(posedge mclk_in) disable iff (sys_rst_in) $changed(rx_data_out) |-> rx_valid_out;
   endproperty
   property p_oe_idle;
      @(posedge ser_clk_in) disable iff (sys_rst_in) ss_n_out |-> &lane_oe_n_out;
   endproperty
   a_launch: assert property (p_launch) else $error("no select after launch");
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   a_done_clr: assert property (p_done_clr) else $error("busy with done");
   a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
   a_ss_busy: assert property (p_ss_busy) else $error("select while idle");
   a_rx_busy: assert property (p_rx_busy) else $error("frame while idle");
   a_rx_pulse: assert property (p_rx_pulse) else $error("frame strobe too long");
   a_rx_hold: assert property (p_rx_hold) else $error("rx data moved");
   a_oe_idle: assert property (p_oe_idle) else $error("lane driven unselected");
endmodule
bind wsd_ctrl wsd_chk wsd_chk_i (.mclk_in, .sys_rst_in, .ser_clk_in, .data_port_wr_in, .busy_out,
   .done_out, .rx_valid_out, .rx_data_out, .ss_n_out, .lane_oe_n_out);
`default_nettype wire

// ### dv/wsd_target.sv
`timescale 1ns/1ns
`default_nettype none
module wsd_target (
   input  wire logic       ser_clk_in,
   input  wire logic       ss_n_in,
   input  wire logic [7:0] lane_oe_n_in,
   input  wire logic [1:0] frf_in,
   input  wire logic [7:0] pat_in,
   output logic [7:0]      rxd_out
);
   logic [7:0] junk_q = 8'h5a;
   logic [7:0] mask;
   logic       live;
   // undriven lanes wander so a wrong lane choice cannot pass by luck
   always @(posedge ser_clk_in) junk_q <= junk_q + 8'h3b;
   always_comb begin
      case (frf_in)
         2'h0: mask = 8'h02;
         2'h1: mask = 8'h03;
         2'h2: mask = 8'h0f;
         default: mask = 8'hff;
      endcase
   end
   // answers only once the controller has let go of every lane
   assign live = !ss_n_in && &lane_oe_n_in;
   assign rxd_out = live ? ((pat_in & mask) | (junk_q & ~mask)) : junk_q;
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic mclk = 0, sck = 0, rst = 1, wr = 0, rd = 0, cpha = 0, cpol = 0, ddr = 0, iddr = 0;
   logic [15:0] instr = 16'h0, fc = 16'h0;
   logic [59:0] addr = 60'h0;
   logic [1:0]  frf = 2'h0, pfs = 2'h0, ilen = 2'h0;
   logic [3:0]  alen = 4'h0;
   logic [4:0]  wt = 5'h0;
   logic [5:0]  fb = 6'h08;
   logic [7:0]  baud = 8'h03, pat = 8'h0, rxd, txd, oe_n, oe_seen = 8'hff;
   logic [31:0] rx_data, lfsr = 32'h5033, v;
   logic        busy, done, rxv, sclk, ss_n;
   int          num_errors = 0, comparisons = 0, nrx = 0;
   always #20 mclk = ~mclk;
   always begin
      #62 sck = ~sck;
      #63 sck = ~sck;
   end
   wsd_ctrl wsd_ctrl_i (.mclk_in(mclk), .sys_rst_in(rst), .ser_clk_in(sck), .data_port_wr_in(wr),
      .xfer_read_in(rd), .instr_in(instr), .addr_in(addr), .wide_frame_format_in(frf),
      .phase_format_select_in(pfs), .instr_length_code_in(ilen), .addr_length_code_in(alen),
      .wait_count_in(wt), .frame_count_in(fc), .frame_bits_in(fb), .clock_phase_in(cpha),
      .clock_polarity_in(cpol), .addr_data_ddr_en_in(ddr), .double_rate_instr_en_in(iddr),
      .baud_half_in(baud), .rxd_in(rxd), .busy_out(busy), .done_out(done), .rx_valid_out(rxv),
      .rx_data_out(rx_data), .sclk_out(sclk), .ss_n_out(ss_n), .txd_out(txd), .lane_oe_n_out(oe_n));
   wsd_target wsd_target_i (.ser_clk_in(sck), .ss_n_in(ss_n), .lane_oe_n_in(oe_n), .frf_in(frf),
      .pat_in(pat), .rxd_out(rxd));
   function automatic logic [31:0] lfsr_next();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [31:0] exp_data(input logic [1:0] f, input logic [7:0] p, input logic [5:0] b);
      int l;
      logic [31:0] r;
      l = 1 << f;
      r = 32'h0;
      for (int i = 0; i < b; i += l) r = (r << l) | (f == 2'h0 ? {31'h0, p[1]} : 32'(p) & ((32'h1 << l) - 32'h1));
      return r;
   endfunction
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // lanes ever driven while selected, sampled away from the link clock's launch edge
   always @(negedge sck) begin
      if (ss_n === 1'b0) oe_seen <= oe_seen & oe_n;
   end
   always @(negedge mclk) begin
      if (rxv === 1'b1) begin
         nrx++;
         check("rx_data", rx_data, exp_data(frf, pat, fb));
      end
   end
   task automatic xfer(input logic r, input logic [1:0] f, input logic [1:0] p, input logic [1:0] il,
                       input logic [3:0] al, input logic [4:0] w, input logic twice);
      int n;
      v = lfsr_next();
      @(posedge mclk);
      #2;
      rd = r;
      frf = f;
      pfs = p;
      ilen = il;
      alen = al;
      wt = w;
      instr = v[15:0] | 16'h1;
      addr = {v, v[27:0]} | 60'h1;
      fc = {14'h0, v[17:16]};
      fb = v[19] ? 6'h10 : (v[18] ? 6'h20 : 6'h08);
      {iddr, ddr, cpol, cpha} = v[23:20];
      baud = {7'h01, v[24]};
      pat = v[31:24];
      nrx = 0;
      oe_seen = 8'hff;
      wr = 1;
      @(posedge mclk);
      #2 wr = 0;
      if (twice) begin
         repeat (3) @(posedge mclk);
         #2 wr = 1;
         @(posedge mclk);
         #2 wr = 0;
      end
      for (n = 0; n < 30000; n++) begin
         @(negedge mclk);
         if (done === 1'b1) break;
      end
      if (n == 30000) begin
         num_errors++;
         print_verdict();
      end
      check("busy", busy, 64'h0);
      check("frames", 64'(nrx), r ? 64'(fc) + 64'h1 : 64'h0);
      repeat (4) @(negedge mclk);
      check("idle", {busy, ss_n, sclk, oe_n}, {2'b01, cpol, 8'hff});
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      #2 rst = 0;
      check("reset", {busy, done, rxv, ss_n, oe_n}, {4'b0001, 8'hff});
      xfer(1'b0, 2'h2, 2'h2, 2'h2, 4'h0, 5'h00, 1'b0);
      check("wide_oe", {56'h0, oe_seen}, 64'hf0);
      xfer(1'b1, 2'h1, 2'h0, 2'h0, 4'h0, 5'h03, 1'b0);
      xfer(1'b1, 2'h2, 2'h1, 2'h2, 4'hf, 5'h01, 1'b1);
      xfer(1'b1, 2'h3, 2'h2, 2'h3, 4'h8, 5'h00, 1'b0);
      for (int i = 0; i < 16; i++) begin
         v = lfsr_next();
         xfer(1'b1, i[1:0], i[3:2], v[1:0], {1'b0, v[4:2]}, {1'b0, v[8:5]}, 1'b0);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
